/* File: src/sbtc_map.svh */
// constants for the sixteen-bit timer/counter: control bit positions,
// reset values and prescaler defaults; definitions only.
// Notes on behaviour
// RQ1 - sixteen-bit free-running counter, advances once per selected prescaled input tick
// RQ2 - four modes: timer, gated timer, synchronous and asynchronous counter; one active
// RQ3 - asynchronous counter mode counts the external input without the clock synchroniser
// RQ4 - with sync selected, external count is synchronised after the prescaler, not before
// RQ5 - timer and gated timer modes count the instruction cycle clock
// RQ6 - both counter modes count edges on the external count input pin
// RQ7 - clock source select sits at bit 1 of the control word
// RQ8 - external clock sync select sits at bit 2 of the control word
// RQ9 - gate accumulate enable sits at bit 6 of the control word
// RQ10 - source 0: gate 0 gives timer, gate 1 gated timer; sync ignored
// RQ11 - source 1: sync 1 gives synchronous, sync 0 asynchronous counter; gate ignored
// RQ12 - gated timer advances on cycle clocks only while gate input is high
`ifndef SBTC_MAP_SVH
`define SBTC_MAP_SVH

`define SBTC_CTL_W 16
`define SBTC_CTL_CS_BIT 1
`define SBTC_CTL_SYNC_BIT 2
`define SBTC_CTL_GATE_BIT 6
`define SBTC_COUNT_W 16
`define SBTC_COUNT_RST 16'h0000
`define SBTC_COUNT_MAX 16'hFFFF
`define SBTC_PRE_W 8
`define SBTC_PRE_DIV 1
`define SBTC_SETTLE_CYC 2'h3

`endif

/* File: src/sbtc_pkg.sv */
// types shared by the timer/counter modules.
// assumes sbtc_map.svh supplies the numeric constants.
package sbtc_pkg;
  // operating mode decoded from the control word
  typedef enum logic [1:0] {
    mode_timer,
    mode_gated,
    mode_sync_cnt,
    mode_async_cnt
  } sbtc_mode_e;
endpackage : sbtc_pkg

/* File: src/sbtc_pre_if.sv */
// link between the timer core and its prescaler.
// assumes one clock shared by both ends.
`timescale 1ns/1ns
interface sbtc_pre_if;
  logic tick_in;
  logic restart;
  logic div_level;
  modport core (output tick_in, output restart, input div_level);
  modport pre (input tick_in, input restart, output div_level);
endinterface : sbtc_pre_if

/* File: src/sbtc_prescale.sv */
// prescaler: toggles a level once every div input ticks.
// assumes ticks are one-cycle pulses on clk; restart clears it.
`timescale 1ns/1ns
`include "sbtc_map.svh"
module sbtc_prescale #(
  parameter int PRE_W = `SBTC_PRE_W,
  parameter logic [PRE_W-1:0] PRE_DIV = PRE_W'(`SBTC_PRE_DIV)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // core side
  sbtc_pre_if.pre pre
);
  logic [PRE_W-1:0] cnt_r;
  logic [PRE_W-1:0] cnt_nxt;
  logic level_r;
  logic level_nxt;
  wire logic at_end;

  // terminal tick of each prescale period
  assign at_end = (cnt_r >= PRE_DIV - PRE_W'(1));
  assign cnt_nxt = pre.restart ? '0 : (pre.tick_in ? (at_end ? '0 : cnt_r + PRE_W'(1)) : cnt_r);
  assign level_nxt = pre.restart ? 1'b0 : ((pre.tick_in && at_end) ? ~level_r : level_r);
  assign pre.div_level = level_r;

  // period counter and output level
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_r <= '0;
      level_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      level_r <= level_nxt;
    end
  end
endmodule : sbtc_prescale

/* File: src/sbtc_top.sv */
// sixteen-bit timer/counter core with four modes and a prescaler.
// control word, enable, load and pins feed one free-running count.
// assumes all inputs synchronous to clk, which is the instruction cycle clock.
// assumes the external pin is already clean and sampled on clk.
`timescale 1ns/1ns
`include "sbtc_map.svh"
module sbtc_top #(
  parameter int PRE_W = `SBTC_PRE_W,
  parameter logic [PRE_W-1:0] PRE_DIV = PRE_W'(`SBTC_PRE_DIV)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // configuration
  input wire logic [`SBTC_CTL_W-1:0] timer_control_reg,
  input wire logic timer_on,
  // counter load
  input wire logic load,
  input wire logic [`SBTC_COUNT_W-1:0] load_value,
  // pins
  input wire logic external_count_input,
  input wire logic gate_in,
  // status
  output logic [`SBTC_COUNT_W-1:0] count,
  output logic rollover,
  output sbtc_pkg::sbtc_mode_e mode
);
  sbtc_pre_if pre_link ();

  // control fields
  wire logic clock_source_select;
  wire logic ext_clock_sync_select;
  wire logic gate_accumulate_enable;
  assign clock_source_select = timer_control_reg[`SBTC_CTL_CS_BIT]; // [RQ7]
  assign ext_clock_sync_select = timer_control_reg[`SBTC_CTL_SYNC_BIT]; // [RQ8]
  assign gate_accumulate_enable = timer_control_reg[`SBTC_CTL_GATE_BIT]; // [RQ9]

  // mode decode, exactly one active
  function automatic sbtc_pkg::sbtc_mode_e decode_mode(
    input logic cs,
    input logic sy,
    input logic gt
  );
    decode_mode = sbtc_pkg::mode_timer;
    unique case (cs)
      // internal clock: gate bit picks plain or gated timing
      1'b0: begin
        decode_mode = gt ? sbtc_pkg::mode_gated : sbtc_pkg::mode_timer; // [RQ10]
      end
      // pin clock: sync bit picks the counter flavour
      1'b1: begin
        decode_mode = sy ? sbtc_pkg::mode_sync_cnt : sbtc_pkg::mode_async_cnt; // [RQ11]
      end
    endcase
  endfunction : decode_mode

  // level change between two samples, one-cycle pulse
  function automatic logic toggled(input logic now_lvl, input logic prev_lvl);
    toggled = now_lvl ^ prev_lvl;
  endfunction : toggled

  wire sbtc_pkg::sbtc_mode_e mode_nxt;
  assign mode_nxt = decode_mode(clock_source_select, ext_clock_sync_select,
                                gate_accumulate_enable); // [RQ2]

  // mode and enable state
  sbtc_pkg::sbtc_mode_e mode_r;
  logic on_r;

  // synchroniser and edge history
  logic ext_prev_r;
  logic div_prev_r;
  logic sync1_r;
  logic sync2_r;
  logic sync2_prev_r;

  // settle, counter and wrap state
  logic [1:0] settle_r;
  logic [1:0] settle_nxt;
  logic [`SBTC_COUNT_W-1:0] count_r;
  logic [`SBTC_COUNT_W-1:0] count_nxt;
  logic rollover_r;
  logic rollover_nxt;

  // restart prescaler whenever mode or enable changes
  wire logic reconfig;
  assign reconfig = (mode_nxt != mode_r) || (timer_on != on_r);

  // raw tick into the prescaler
  wire logic ext_rise;
  wire logic cycle_tick;
  assign ext_rise = external_count_input && !ext_prev_r; // [RQ6]
  assign cycle_tick = (mode_r == sbtc_pkg::mode_timer) ||
                      (mode_r == sbtc_pkg::mode_gated && gate_in); // [RQ5] [RQ12]
  assign pre_link.tick_in = on_r && (clock_source_select ? ext_rise : cycle_tick);
  assign pre_link.restart = reconfig || !timer_on;

  sbtc_prescale #(
    .PRE_W(PRE_W),
    .PRE_DIV(PRE_DIV)
  ) u_pre (
    .clk(clk),
    .rst_b(rst_b),
    .pre(pre_link)
  );

  // prescaler output edges, direct and synchronised
  wire logic async_edge;
  wire logic sync_edge;
  wire logic sel_edge;
  assign async_edge = toggled(pre_link.div_level, div_prev_r); // [RQ3]
  assign sync_edge = toggled(sync2_r, sync2_prev_r); // [RQ4]
  assign sel_edge = (mode_r == sbtc_pkg::mode_sync_cnt) ? sync_edge : async_edge;

  // counter next state; ignore edges while the pipeline settles
  wire logic advance;
  wire logic [`SBTC_COUNT_W-1:0] count_inc;
  assign advance = on_r && (settle_r == 2'h0) && sel_edge;
  assign settle_nxt = reconfig ? `SBTC_SETTLE_CYC : (settle_r != 2'h0 ? settle_r - 2'h1 : 2'h0);
  // one step up, wraps from all ones to zero
  assign count_inc = count_r + `SBTC_COUNT_W'(1); // [RQ1]
  // a load wins over a count in the same cycle
  assign count_nxt = load ? load_value : (advance ? count_inc : count_r); // [RQ1]
  assign rollover_nxt = !load && advance && (count_r == `SBTC_COUNT_MAX);

  // pin history for rising-edge detect, idle low like the pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= external_count_input;
    end
  end

  // prescaler level history for the direct path
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_prev_r <= 1'b0;
    end else begin
      div_prev_r <= pre_link.div_level;
    end
  end

  // first synchroniser stage, read only by the second
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1_r <= 1'b0;
    end else begin
      sync1_r <= pre_link.div_level; // [RQ4]
    end
  end

  // second synchroniser stage
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync2_r <= 1'b0;
    end else begin
      sync2_r <= sync1_r;
    end
  end

  // synchronised level history for the sync path
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync2_prev_r <= 1'b0;
    end else begin
      sync2_prev_r <= sync2_r;
    end
  end

  // registered mode
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_r <= sbtc_pkg::mode_timer;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // registered enable, compared to spot a restart
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      on_r <= 1'b0;
    end else begin
      on_r <= timer_on;
    end
  end

  // blanking after reset or reconfiguration
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      settle_r <= `SBTC_SETTLE_CYC;
    end else begin
      settle_r <= settle_nxt;
    end
  end

  // the count itself
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_r <= `SBTC_COUNT_RST;
    end else begin
      count_r <= count_nxt; // [RQ1]
    end
  end

  // one-cycle wrap pulse
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rollover_r <= 1'b0;
    end else begin
      rollover_r <= rollover_nxt;
    end
  end

  // outputs straight from their flip-flops
  assign count = count_r;
  assign rollover = rollover_r;
  assign mode = mode_r;
endmodule : sbtc_top

/* File: sim/sbtc_ext_src.sv */
// far-side model: external count pin and gate source.
// assumes calls start just after a rising clk edge.
`timescale 1ns/1ns
module sbtc_ext_src (
  // clock
  input wire logic clk,
  // pins toward the timer
  output logic ext,
  output logic gate
);
  // idle low outside pulses
  initial begin
    ext = 1'b0;
    gate = 1'b0;
  end
  // one rising edge, held hi cycles
  task automatic pulse(input int hi);
    ext <= 1'b1;
    repeat (hi) @(posedge clk);
    ext <= 1'b0;
  endtask : pulse
endmodule : sbtc_ext_src

/* File: sim/sbtc_properties.sv */
// checker on the timer/counter top ports.
// assumes PRE_DIV of 1; bound to sbtc_top below.
`timescale 1ns/1ns
module sbtc_properties #(
  parameter int PRE_W = 8,
  parameter logic [PRE_W-1:0] PRE_DIV = 8'h01
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // configuration and load
  input wire logic [15:0] timer_control_reg,
  input wire logic timer_on,
  input wire logic load,
  input wire logic [15:0] load_value,
  // pins
  input wire logic external_count_input,
  input wire logic gate_in,
  // status
  input wire logic [15:0] count,
  input wire logic rollover,
  input wire sbtc_pkg::sbtc_mode_e mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // control bits and mode flags
  wire cs = timer_control_reg[1];
  wire sy = timer_control_reg[2];
  wire gt = timer_control_reg[6];
  wire m_tm = mode == sbtc_pkg::mode_timer;
  wire m_gt = mode == sbtc_pkg::mode_gated;
  wire m_ex = !m_tm && !m_gt;
  // mode decode and counting
  property p_m0; !cs && !gt |=> m_tm; endproperty
  a_m0: assert property (p_m0) else $error("timer mode wrong");
  property p_m1; !cs && gt |=> m_gt; endproperty
  a_m1: assert property (p_m1) else $error("gated mode wrong");
  property p_m2; cs && sy |=> mode == sbtc_pkg::mode_sync_cnt; endproperty
  a_m2: assert property (p_m2) else $error("sync mode wrong");
  property p_m3; cs && !sy |=> mode == sbtc_pkg::mode_async_cnt; endproperty
  a_m3: assert property (p_m3) else $error("async mode wrong");
  property p_step; !load |=> count == $past(count) || count == $past(count) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("count jumped");
  property p_wrap; rollover |-> count == 16'h0000 && $past(count) == 16'hFFFF; endproperty
  a_wrap: assert property (p_wrap) else $error("bad rollover");
  property p_gate; (m_gt && !gate_in && !load)[*4] |=> $stable(count); endproperty
  a_gate: assert property (p_gate) else $error("counted with gate low");
  property p_ext; (m_ex && !external_count_input && !load)[*6] |=> $stable(count); endproperty
  a_ext: assert property (p_ext) else $error("counted without pin edge");
  property p_run; (m_tm && timer_on && !load && $stable(timer_control_reg))[*8]
    |=> count == $past(count) + 16'h0001; endproperty
  a_run: assert property (p_run) else $error("timer not counting");
  c_wrap: cover property (rollover);
  c_sync: cover property (mode == sbtc_pkg::mode_sync_cnt && $changed(count));
  c_gate: cover property (m_gt && gate_in);
endmodule : sbtc_properties
bind sbtc_top sbtc_properties #(.PRE_W(PRE_W), .PRE_DIV(PRE_DIV)) chk_u (.clk, .rst_b,
  .timer_control_reg, .timer_on, .load, .load_value, .external_count_input, .gate_in,
  .count, .rollover, .mode);

/* File: sim/sixteen_bit_timer_counter_bench.sv */
// bench for the timer/counter: modes, counting, gating, wrap, pin counting.
// assumes design, far-side model and checker compiled before it.
`timescale 1ns/1ns
`include "sbtc_map.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module sixteen_bit_timer_counter_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] ctl = 16'h0000;
  logic on = 1'b0;
  logic load = 1'b0;
  logic [15:0] lv = 16'h0000;
  logic ext, gate, roll;
  logic [15:0] count, c0;
  sbtc_pkg::sbtc_mode_e mode;
  int fails = 0;
  int total_checks = 0;
  // 10 MHz clock
  always #50 clk = ~clk;
  sbtc_top dut_u (.clk, .rst_b, .timer_control_reg(ctl), .timer_on(on), .load,
    .load_value(lv), .external_count_input(ext), .gate_in(gate), .count, .rollover(roll),
    .mode);
  sbtc_ext_src src_u (.clk, .ext, .gate);
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  task automatic cfg(input logic [15:0] v);
    ctl <= v;
    on <= 1'b1;
    step(12);
    c0 = count;
  endtask : cfg
  // every bit combination, unused bits set
  task automatic t_modes;
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 16'hFFB9;
      v[`SBTC_CTL_CS_BIT] = i[0];
      v[`SBTC_CTL_SYNC_BIT] = i[1];
      v[`SBTC_CTL_GATE_BIT] = i[2];
      ctl <= v;
      step(2);
      `CHK(mode, i[0] ? (i[1] ? 2'h2 : 2'h3) : (i[2] ? 2'h1 : 2'h0))
    end
  endtask : t_modes
  // steady count, wrap, then freeze
  task automatic t_timer;
    cfg(16'h0000);
    step(5);
    `CHK(count, c0 + 16'h0005)
    load <= 1'b1;
    lv <= 16'hFFFD;
    step(1);
    load <= 1'b0;
    repeat (20) if (roll !== 1'b1) step(1);
    `CHK(roll, 1'b1)
    if (roll !== 1'b1) end_sim();
    `CHK(count, 16'h0000)
    on <= 1'b0;
    step(2);
    c0 = count;
    step(4);
    `CHK(count, c0)
  endtask : t_timer
  // gate low holds, five gate-high cycles give five counts
  task automatic t_gated;
    cfg(16'h0040);
    step(4);
    `CHK(count, c0)
    src_u.gate <= 1'b1;
    step(5);
    src_u.gate <= 1'b0;
    step(6);
    `CHK(count, c0 + 16'h0005)
  endtask : t_gated
  // pin edges counted, gate ignored, sync path two cycles later
  task automatic t_count(input logic [15:0] v, input logic sy);
    cfg(v);
    src_u.gate <= 1'b1;
    src_u.pulse(1);
    step(3);
    `CHK(count, c0 + {15'h0000, !sy})
    step(2);
    `CHK(count, c0 + 16'h0001)
    src_u.pulse(3);
    step(8);
    `CHK(count, c0 + 16'h0002)
    src_u.gate <= 1'b0;
  endtask : t_count
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  // reset for 3 cycles, then the scenarios
  initial begin
    step(3);
    rst_b <= 1'b1;
    step(1);
    `CHK(count, 16'h0000)
    t_modes();
    t_timer();
    t_gated();
    t_count(16'h0042, 1'b0);
    t_count(16'h0046, 1'b1);
    end_sim();
  end
endmodule : sixteen_bit_timer_counter_bench
